// ==== inc/tlv_pkg.sv ====
/*
 * Constants, types and source numbering for the two level vectored
 * interrupt unit.
 * Assumes a single system clock and special registers reached through
 * the core's own special register port.
 */
package tlv_pkg;

   // ************************************************************
   // Special register map
   // ************************************************************
   localparam logic [7:0] IRQ_ENABLE_PRIMARY_ADDR  = 8'hA8;
   localparam logic [7:0] IRQ_ENABLE_PRIMARY_RESET = 8'h00;
   localparam logic [4:0] IRQ_ENABLE_BIT_BASE      = 5'h15;

   // Enable bit positions
   localparam int GLOBAL_IRQ_GATE_BIT     = 7;
   localparam int SYNC_SERIAL_IRQ_EN_BIT  = 6;
   localparam int TIMER_TWO_IRQ_EN_BIT    = 5;
   localparam int ASYNC_SERIAL_IRQ_EN_BIT = 4;
   localparam int TIMER_ONE_IRQ_EN_BIT    = 3;
   localparam int EXT_INPUT_B_IRQ_EN_BIT  = 2;
   localparam int TIMER_ZERO_IRQ_EN_BIT   = 1;
   localparam int EXT_INPUT_A_IRQ_EN_BIT  = 0;

   // ************************************************************
   // Source numbering and vectors
   // ************************************************************
   localparam int NUM_ORDERS   = 18;
   localparam int NUM_PRIMARY  = 7;
   localparam int NUM_EXTENDED = 10;
   localparam int ORDER_DROPOUT = 15;
   localparam int ORDER_UNUSED  = 16;
   localparam int ORDER_PORT_MATCH = 17;
   localparam logic [15:0] VEC_RESET      = 16'h0000;
   localparam logic [15:0] VEC_BASE       = 16'h0003;
   localparam logic [15:0] VEC_STEP       = 16'h0008;
   localparam logic [15:0] VEC_DROPOUT    = 16'h007B;
   localparam logic [15:0] VEC_PORT_MATCH = 16'h008B;

   // ************************************************************
   // Timing in system clocks
   // ************************************************************
   localparam int DETECT_CYCLES = 1;
   localparam int CALL_CYCLES   = 4;
   localparam logic [1:0] CALL_LAST = 2'(CALL_CYCLES - 1);

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic [3:0] sync_serial_port;
      logic       timer_two_high_overflow;
      logic       timer_two_low_overflow;
      logic       async_tx_done;
      logic       async_rx_done;
      logic       timer_one_overflow;
      logic       ext_b_pending;
      logic       timer_zero_overflow;
      logic       ext_a_pending;
   } tlv_flags_t;

   typedef struct packed {
      logic timer_one_overflow;
      logic ext_b_pending;
      logic timer_zero_overflow;
      logic ext_a_pending;
   } tlv_hw_clear_t;

   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
      logic       bit_wr;
      logic [7:0] bit_addr;
      logic       bit_val;
   } tlv_sfr_req_t;

   typedef enum logic {TLV_IDLE, TLV_CALL} tlv_state_t;

endpackage

// ==== logic/tlv_irq_unit.sv ====
/*
 * Two level vectored interrupt unit: primary enable register, request
 * gating, priority resolution, vector generation and in service
 * tracking around the core's long call and return sequencing.
 * Assumes the core reports instruction boundaries and return
 * completion, and peripherals hold their pending flags as levels.
 */

// Functional notes
// - Sample and resolve every clock; 1+4 latency
// - One instruction after return before long call
// - Worst case response 18 clocks
// - Equal or higher running routine blocks new
// - Fixed vector per source order
// - Same level: smaller order number wins
// - Global gate bit 7 overrides masks
// - Bit 6 gates sync serial group
// - Bit 5 gates timer two either flag
// - Bit 4 gates async serial either flag
// - Bits 3 and 1 gate timers one, zero
// - Bits 2 and 0 gate external inputs
// - Enable register at 0xA8, bit access, all pages
// - Flags set regardless of enables
// - High preempts low; high never preempted
// - Flag still set after return re-requests
// - Simultaneous: high level served first
module tlv_irq_unit (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire tlv_pkg::tlv_sfr_req_t  sfr_req,
   output logic [7:0]                  sfr_rdata,
   input  wire tlv_pkg::tlv_flags_t    flags,
   input  wire logic [6:0]             primary_hi,
   input  wire logic [9:0]             ext_pending,
   input  wire logic [9:0]             ext_enable,
   input  wire logic [9:0]             ext_hi,
   input  wire logic                   instr_boundary,
   input  wire logic                   return_from_irq,
   output logic                        long_call,
   output logic [15:0]                 vector_addr,
   output tlv_pkg::tlv_hw_clear_t      hw_clear,
   output logic                        active_hi,
   output logic                        active_lo
);

   // ************************************************************
   // Helper functions
   // ************************************************************
   function automatic logic [4:0] first_set(
      input logic [tlv_pkg::NUM_ORDERS-1:0] v
   );
      logic [4:0] idx;
      idx = 5'h00;
      for (int i = tlv_pkg::NUM_ORDERS - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic [15:0] vector_of(input logic [4:0] order);
      logic [15:0] v;
      v = tlv_pkg::VEC_RESET;
      if (order == 5'(tlv_pkg::ORDER_DROPOUT)) begin
         v = tlv_pkg::VEC_DROPOUT;
      end else if (order == 5'(tlv_pkg::ORDER_PORT_MATCH)) begin
         v = tlv_pkg::VEC_PORT_MATCH;
      end else if (order < 5'(tlv_pkg::ORDER_DROPOUT)) begin
         v = 16'(tlv_pkg::VEC_BASE
                 + 16'(order) * tlv_pkg::VEC_STEP);
      end
      return v;
   endfunction

   function automatic logic reg_hit(input tlv_pkg::tlv_sfr_req_t r);
      return r.addr == tlv_pkg::IRQ_ENABLE_PRIMARY_ADDR;
   endfunction

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [7:0]                  irq_enable_primary_reg;
   logic [7:0]                  sfr_rdata_reg;
   logic [tlv_pkg::NUM_PRIMARY-1:0] prim_src;
   logic [tlv_pkg::NUM_ORDERS-1:0]  req_all;
   logic [tlv_pkg::NUM_ORDERS-1:0]  lvl_hi;
   logic [tlv_pkg::NUM_ORDERS-1:0]  req_hi;
   logic                        global_irq_gate;
   logic                        det_valid_reg;
   logic                        det_hi_reg;
   logic [4:0]                  det_idx_reg;
   tlv_pkg::tlv_state_t         state_reg;
   logic [1:0]                  call_cnt_reg;
   logic                        call_hi_reg;
   logic [15:0]                 vector_reg;
   logic                        active_hi_reg;
   logic                        active_lo_reg;
   logic                        post_return_reg;
   tlv_pkg::tlv_hw_clear_t      hw_clear_reg;
   logic                        allowed;
   logic                        take;
   logic                        call_done;

   // ************************************************************
   // Primary enable register
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_enable_primary_reg <= tlv_pkg::IRQ_ENABLE_PRIMARY_RESET;
      end else if (sfr_req.wr && reg_hit(sfr_req)) begin
         irq_enable_primary_reg <= sfr_req.wdata;
      end else if (sfr_req.bit_wr
                   && sfr_req.bit_addr[7:3]
                      == tlv_pkg::IRQ_ENABLE_BIT_BASE) begin
         irq_enable_primary_reg[sfr_req.bit_addr[2:0]]
            <= sfr_req.bit_val;
      end
   end

   // Read data, zero for any other address
   always_ff @(posedge clk) begin
      if (rst) begin
         sfr_rdata_reg <= 8'h00;
      end else if (sfr_req.rd) begin
         sfr_rdata_reg <= reg_hit(sfr_req)
                          ? irq_enable_primary_reg : 8'h00;
      end
   end

   assign sfr_rdata = sfr_rdata_reg;

   // ************************************************************
   // Request gating
   // ************************************************************
   assign global_irq_gate =
      irq_enable_primary_reg[tlv_pkg::GLOBAL_IRQ_GATE_BIT];

   // Flags arrive as levels whatever the enables; gating is here only
   always_comb begin
      prim_src[0] = flags.ext_a_pending;
      prim_src[1] = flags.timer_zero_overflow;
      prim_src[2] = flags.ext_b_pending;
      prim_src[3] = flags.timer_one_overflow;
      prim_src[4] = flags.async_rx_done | flags.async_tx_done;
      prim_src[5] = flags.timer_two_low_overflow
                    | flags.timer_two_high_overflow;
      prim_src[6] = |flags.sync_serial_port;
   end

   genvar g;
   generate
      for (g = 0; g < tlv_pkg::NUM_PRIMARY; g++) begin : g_prim
         // Bits 0..6 gate orders 0..6 one for one
         assign req_all[g] = global_irq_gate
                             & irq_enable_primary_reg[g]
                             & prim_src[g];
         assign lvl_hi[g]  = primary_hi[g];
      end
      for (g = 0; g < tlv_pkg::NUM_EXTENDED; g++) begin : g_ext
         // Orders 7..15 then port match at 17
         localparam int ORD = (g < 9) ? g + tlv_pkg::NUM_PRIMARY
                                      : tlv_pkg::ORDER_PORT_MATCH;
         assign req_all[ORD] = global_irq_gate
                               & ext_enable[g] & ext_pending[g];
         assign lvl_hi[ORD]  = ext_hi[g];
      end
   endgenerate

   assign req_all[tlv_pkg::ORDER_UNUSED] = 1'b0;
   assign lvl_hi[tlv_pkg::ORDER_UNUSED]  = 1'b0;
   assign req_hi = req_all & lvl_hi;

   // ************************************************************
   // Detect stage, resolved every clock
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         det_valid_reg <= 1'b0;
         det_hi_reg    <= 1'b0;
         det_idx_reg   <= 5'h00;
      end else begin
         det_valid_reg <= |req_all;
         det_hi_reg    <= |req_hi;
         det_idx_reg   <= (|req_hi) ? first_set(req_hi)
                                    : first_set(req_all);
      end
   end

   // ************************************************************
   // Vectoring decision
   // ************************************************************
   // High may enter over a running low routine, never over high
   assign allowed = det_hi_reg ? !active_hi_reg
                               : !(active_hi_reg || active_lo_reg);

   // One full instruction must finish after a return first
   assign take = (state_reg == tlv_pkg::TLV_IDLE) && det_valid_reg
                 && instr_boundary && allowed
                 && !post_return_reg && !return_from_irq;

   assign call_done = (state_reg == tlv_pkg::TLV_CALL)
                      && (call_cnt_reg == tlv_pkg::CALL_LAST);

   // ************************************************************
   // Long call sequencer
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg    <= tlv_pkg::TLV_IDLE;
         call_cnt_reg <= 2'h0;
         call_hi_reg  <= 1'b0;
         vector_reg   <= tlv_pkg::VEC_RESET;
      end else begin
         unique case (state_reg)
            tlv_pkg::TLV_IDLE: begin
               call_cnt_reg <= 2'h0;
               if (take) begin
                  state_reg   <= tlv_pkg::TLV_CALL;
                  call_hi_reg <= det_hi_reg;
                  vector_reg  <= vector_of(det_idx_reg);
               end
            end
            tlv_pkg::TLV_CALL: begin
               call_cnt_reg <= 2'(call_cnt_reg + 2'h1);
               if (call_done) begin
                  state_reg <= tlv_pkg::TLV_IDLE;
               end
            end
         endcase
      end
   end

   assign long_call   = (state_reg == tlv_pkg::TLV_CALL);
   assign vector_addr = vector_reg;

   // ************************************************************
   // Hardware flag clearing
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         hw_clear_reg <= '0;
      end else begin
         hw_clear_reg <= '0;
         if (take) begin
            unique case (det_idx_reg)
               5'h00: hw_clear_reg.ext_a_pending       <= 1'b1;
               5'h01: hw_clear_reg.timer_zero_overflow <= 1'b1;
               5'h02: hw_clear_reg.ext_b_pending       <= 1'b1;
               5'h03: hw_clear_reg.timer_one_overflow  <= 1'b1;
               default: hw_clear_reg <= '0;
            endcase
         end
      end
   end

   assign hw_clear = hw_clear_reg;

   // ************************************************************
   // In service tracking
   // ************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         active_hi_reg <= 1'b0;
         active_lo_reg <= 1'b0;
      end else if (call_done) begin
         if (call_hi_reg) begin
            active_hi_reg <= 1'b1;
         end else begin
            active_lo_reg <= 1'b1;
         end
      end else if (return_from_irq) begin
         if (active_hi_reg) begin
            active_hi_reg <= 1'b0;
         end else begin
            active_lo_reg <= 1'b0;
         end
      end
   end

   // Hold off until the instruction after the return completes
   always_ff @(posedge clk) begin
      if (rst) begin
         post_return_reg <= 1'b0;
      end else if (return_from_irq) begin
         post_return_reg <= 1'b1;
      end else if (instr_boundary) begin
         post_return_reg <= 1'b0;
      end
   end

   assign active_hi = active_hi_reg;
   assign active_lo = active_lo_reg;

endmodule

// ==== test/tlv_irq_unit_assertions.sv ====
/* Port checker for the interrupt unit, bound into every instance.
   Assumes one clock and a synchronous active high reset. */
module tlv_irq_unit_chk (
   input wire logic                   clk,
   input wire logic                   rst,
   input wire tlv_pkg::tlv_sfr_req_t  sfr_req,
   input wire logic [7:0]             sfr_rdata,
   input wire logic                   return_from_irq,
   input wire logic                   long_call,
   input wire logic [15:0]            vector_addr,
   input wire tlv_pkg::tlv_hw_clear_t hw_clear,
   input wire logic                   active_hi,
   input wire logic                   active_lo
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Port relations
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   chk_call_len: assert property (
      $rose(long_call) |-> long_call[*4] ##1 !long_call)
      else $error("long call length wrong");
   chk_active_set: assert property (
      $fell(long_call) |-> active_hi || active_lo)
      else $error("no routine in service after call");
   chk_ret_gap: assert property (
      return_from_irq |=> !long_call)
      else $error("call started in return cycle");
   chk_nest_level: assert property (
      $rose(long_call) && active_lo |-> ##4 active_hi)
      else $error("low routine entered over low routine");
   chk_hi_no_preempt: assert property (
      $rose(long_call) |-> !active_hi)
      else $error("high routine preempted");
   chk_ret_pop: assert property (
      return_from_irq && active_hi && active_lo |=> !active_hi && active_lo)
      else $error("return popped wrong level");
   chk_vec_form: assert property (
      $rose(long_call) |-> vector_addr[2:0] == 3'h3
         && vector_addr <= 16'h008B && vector_addr != 16'h0083)
      else $error("vector outside table");
   chk_vec_hold: assert property (
      !$rose(long_call) |-> $stable(vector_addr))
      else $error("vector changed without call");
   chk_clear_match: assert property (
      $rose(long_call) |-> hw_clear == (vector_addr < 16'h0020 ?
         4'h1 << vector_addr[4:3] : 4'h0))
      else $error("hardware clear does not match vector");
   chk_clear_stray: assert property (
      hw_clear != 4'h0 |-> $rose(long_call))
      else $error("hardware clear outside call start");
   chk_rd_hold: assert property (
      !$past(sfr_req.rd) |-> $stable(sfr_rdata))
      else $error("read data changed without read");
   chk_reset_state: assert property (
      $fell(rst) |-> !long_call && !active_hi && !active_lo
         && sfr_rdata == 8'h00 && vector_addr == 16'h0000)
      else $error("outputs not idle after reset");
endmodule

bind tlv_irq_unit tlv_irq_unit_chk i_tlv_irq_unit_chk (
   .clk(clk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
   .return_from_irq(return_from_irq), .long_call(long_call),
   .vector_addr(vector_addr), .hw_clear(hw_clear),
   .active_hi(active_hi), .active_lo(active_lo));

// ==== test/tlv_core_model.sv ====
/* Core and peripheral flag model: pending flag levels and instruction
   boundaries, quick or divide paced.
   Assumes the bench pulses flag sets, software clears and returns. */
module tlv_core_model (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   slow,
   input  wire logic                   return_from_irq,
   input  wire tlv_pkg::tlv_flags_t    set_flags,
   input  wire tlv_pkg::tlv_flags_t    sw_clear,
   input  wire tlv_pkg::tlv_hw_clear_t hw_clear,
   output tlv_pkg::tlv_flags_t         flags,
   output logic                        instr_boundary
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] div_cnt_reg;

   // Flags set by events, cleared by software or on vectoring
   always_ff @(posedge clk) begin
      if (rst)
         flags <= 12'h000;
      else
         flags <= (flags | set_flags) & ~sw_clear & ~{8'h00, hw_clear};
   end

   // Eight cycle divide pacing when slow
   always_ff @(posedge clk) begin
      if (rst)
         div_cnt_reg <= 3'h0;
      else
         div_cnt_reg <= div_cnt_reg + 3'h1;
   end
   assign instr_boundary = !slow || div_cnt_reg == 3'h7 || return_from_irq;
endmodule

// ==== test/tb_top.sv ====
/* Self-checking bench for the interrupt unit: registers, gating,
   vectors, priority and nesting.
   Assumes the unit, checker and core model are compiled first. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   tlv_pkg::tlv_sfr_req_t  sfr_req;
   tlv_pkg::tlv_flags_t    flags;
   tlv_pkg::tlv_flags_t    set_flags;
   tlv_pkg::tlv_flags_t    sw_clear;
   tlv_pkg::tlv_hw_clear_t hw_clear;
   logic [7:0]  sfr_rdata;
   logic [6:0]  primary_hi;
   logic [9:0]  ext_pending;
   logic [9:0]  ext_enable;
   logic [9:0]  ext_hi;
   logic        return_from_irq;
   logic        slow;
   logic        rd_d = 1'b0;
   logic        lc_d = 1'b0;
   logic        instr_boundary, long_call, active_hi, active_lo;
   logic [15:0] vector_addr;
   logic [19:0] vq[$];
   logic [7:0]  rq[$];
   int          n_fail = 0;
   int          check_count = 0;
   int          seed = 63536;

   always #2 clk = ~clk;

   tlv_irq_unit i_tlv_irq_unit (.clk(clk), .rst(rst), .sfr_req(sfr_req),
      .sfr_rdata(sfr_rdata), .flags(flags), .primary_hi(primary_hi),
      .ext_pending(ext_pending), .ext_enable(ext_enable), .ext_hi(ext_hi),
      .instr_boundary(instr_boundary), .return_from_irq(return_from_irq),
      .long_call(long_call), .vector_addr(vector_addr),
      .hw_clear(hw_clear), .active_hi(active_hi), .active_lo(active_lo));
   tlv_core_model i_tlv_core_model (.clk(clk), .rst(rst), .slow(slow),
      .return_from_irq(return_from_irq), .set_flags(set_flags),
      .sw_clear(sw_clear), .hw_clear(hw_clear), .flags(flags),
      .instr_boundary(instr_boundary));

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (n_fail == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic sfr(input logic [2:0] op, input logic [7:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      sfr_req <= '{a, op[0], op[1], d, op[2], a, d[0]};
      @(posedge clk);
      sfr_req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      rq.push_back(exp);
      sfr(3'h2, a, 8'h00);
   endtask
   task automatic raise(input tlv_pkg::tlv_flags_t f);
      @(posedge clk);
      set_flags <= f;
      @(posedge clk);
      set_flags <= '0;
   endtask
   task automatic wait_call();
      for (int i = 0; i < 60 && !long_call; i++) @(negedge clk);
      if (!long_call) begin
         n_fail++;
         finish_test();
      end
      for (int i = 0; i < 8 && long_call; i++) @(negedge clk);
   endtask
   task automatic ret(input logic clr);
      @(posedge clk);
      sw_clear <= {12{clr}};
      ext_pending <= clr ? 10'h000 : ext_pending;
      @(posedge clk);
      sw_clear <= '0;
      return_from_irq <= 1'b1;
      @(posedge clk);
      return_from_irq <= 1'b0;
   endtask

   // ************************************************************
   // Result monitor
   // ************************************************************
   always @(posedge clk) rd_d <= sfr_req.rd;
   always @(negedge clk) begin
      if (rd_d)
         check({12'h000, sfr_rdata}, {12'h000, rq.pop_front()});
      if (long_call && !lc_d)
         check({hw_clear, vector_addr}, vq.pop_front());
      lc_d = long_call;
   end

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      logic [7:0] r;
      int k;
      tlv_pkg::tlv_flags_t f;
      sfr_req <= '0;
      set_flags <= '0;
      sw_clear <= '0;
      primary_hi <= '0;
      ext_pending <= '0;
      ext_enable <= '0;
      ext_hi <= '0;
      return_from_irq <= 1'b0;
      slow <= 1'b0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(8'hA8, 8'h00);
      rd(8'hB8, 8'h00);
      r = 8'($random(seed));
      sfr(3'h1, 8'hA8, r & 8'h7F);
      rd(8'hA8, r & 8'h7F);
      sfr(3'h1, 8'hA8, 8'h00);
      sfr(3'h4, 8'hAF, 8'h01);
      sfr(3'h4, 8'hAB, 8'h01);
      rd(8'hA8, 8'h88);
      sfr(3'h1, 8'hA8, 8'h7F);
      raise(12'h001);
      repeat (20) @(posedge clk);
      sfr(3'h1, 8'hA8, 8'hFE);
      repeat (20) @(posedge clk);
      vq.push_back(20'h1_0003);
      sfr(3'h4, 8'hA8, 8'h01);
      wait_call();
      ret(1'b1);
      for (k = 0; k < 7; k++) begin
         slow <= k[0];
         r = 8'($random(seed));
         sfr(3'h1, 8'hA8, 8'h80 | (8'h01 << k));
         f = (k < 4) ? 12'h001 << k : (k < 6) ?
            12'h010 << (2 * (k - 4) + r[0]) : 12'h100 << r[1:0];
         vq.push_back({(k < 4) ? 4'h1 << k : 4'h0,
            16'h0003 + 16'(8 * k)});
         raise(f);
         wait_call();
         ret(1'b1);
      end
      slow <= 1'b0;
      sfr(3'h1, 8'hA8, 8'h83);
      vq.push_back(20'h1_0003);
      vq.push_back(20'h2_000B);
      raise(12'h003);
      wait_call();
      ret(1'b0);
      wait_call();
      ret(1'b1);
      primary_hi <= 7'h02;
      vq.push_back(20'h2_000B);
      vq.push_back(20'h1_0003);
      raise(12'h003);
      wait_call();
      ret(1'b0);
      wait_call();
      ret(1'b1);
      sfr(3'h1, 8'hA8, 8'h8F);
      vq.push_back(20'h4_0013);
      raise(12'h004);
      wait_call();
      vq.push_back(20'h2_000B);
      vq.push_back(20'h8_001B);
      raise(12'h00A);
      wait_call();
      check({18'h00000, active_hi, active_lo}, 20'h00003);
      ret(1'b0);
      @(negedge clk);
      check({18'h00000, active_hi, active_lo}, 20'h00001);
      ret(1'b0);
      wait_call();
      ret(1'b1);
      primary_hi <= 7'h00;
      sfr(3'h1, 8'hA8, 8'h80);
      for (k = 0; k < 10; k++) begin
         r = 8'($random(seed));
         ext_hi <= {10{r[0]}};
         ext_enable <= 10'h001 << k;
         ext_pending <= (10'h001 << k) | (10'($random(seed)) & ~ext_enable);
         vq.push_back({4'h0, (k < 8) ? 16'h003B + 16'(8 * k) :
            (k == 8) ? 16'h007B : 16'h008B});
         wait_call();
         ret(1'b1);
      end
      finish_test();
   end
endmodule
